//--- rtl/sfrb_bank.sv
// Special function register bank: pointers, power control, timers 0/1
`timescale 1ns/100ps
`include "sfrb_cfg.svh"
module sfrb_bank (
  input wire logic mclk,
  input wire logic srst,
  input wire sfrb_pkg::sfrb_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rbit,
  output logic sfr_rvalid,
  input wire logic active_data_pointer_load,
  input wire logic [15:0] active_data_pointer_value,
  output logic [15:0] active_data_pointer,
  input wire logic wake,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic baud_doubler,
  output logic framing_select,
  output logic [7:0] port_zero_latch,
  input wire logic timer_zero_div_select,
  input wire logic timer_one_div_select,
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic t0_vec,
  input wire logic t1_vec,
  input wire logic x0_vec,
  input wire logic x1_vec,
  output logic timer_zero_overflow,
  output logic timer_one_overflow,
  output logic ext_zero_flag,
  output logic ext_one_flag
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] stack_top_pointer;
  logic [7:0] pointer_a_low;
  logic [7:0] pointer_a_high;
  logic [7:0] pointer_b_low;
  logic [7:0] pointer_b_high;
  logic pointer_select;
  logic user_flag_one;
  logic user_flag_zero;
  logic power_down_request;
  logic idle_request;
  logic timer_zero_run;
  logic timer_one_run;
  logic ext_zero_trigger_type;
  logic ext_one_trigger_type;
  logic [7:0] timer_mode_control;
  logic [7:0] timer_zero_low;
  logic [7:0] timer_zero_high;
  logic [7:0] timer_one_low;
  logic [7:0] timer_one_high;
  sfrb_pkg::sfrb_pwr_t pwr;
  logic [3:0] div12;
  logic [1:0] div4;

  // ****************************************
  // Bus decode
  // ****************************************
  logic bitable;
  logic hit;
  logic we;
  logic [7:0] mask;
  logic [7:0] rd_cur;
  logic [7:0] wv;
  logic [7:0] tctl_val;
  logic [7:0] pwr_val;
  assign bitable = sfr_req.addr[2:0] == 3'h0;
  // Indirect cycles to the upper half belong to RAM, not here
  assign hit = sfr_req.req & sfr_req.direct & sfr_req.addr[7] & (~sfr_req.bit_op | bitable);
  assign we = hit & sfr_req.wr;
  assign mask = 8'h01 << sfr_req.bit_sel;
  assign wv = sfr_req.bit_op ? ((rd_cur & ~mask) | ({8{sfr_req.bit_val}} & mask)) : sfr_req.wdata;
  assign tctl_val = {timer_one_overflow, timer_one_run, timer_zero_overflow, timer_zero_run,
                     ext_one_flag, ext_one_trigger_type, ext_zero_flag, ext_zero_trigger_type};
  // Bits 5..4 are absent and read high
  assign pwr_val = {baud_doubler, framing_select, 2'h3, user_flag_one, user_flag_zero,
                    power_down_request, idle_request};
  always_comb
  begin
    case (sfr_req.addr)
      `SFRB_A_PZL: rd_cur = port_zero_latch;
      `SFRB_A_STP: rd_cur = stack_top_pointer;
      `SFRB_A_PAL: rd_cur = pointer_a_low;
      `SFRB_A_PAH: rd_cur = pointer_a_high;
      `SFRB_A_PBL: rd_cur = pointer_b_low;
      `SFRB_A_PBH: rd_cur = pointer_b_high;
      `SFRB_A_PSEL: rd_cur = {7'h00, pointer_select};
      `SFRB_A_PWR: rd_cur = pwr_val;
      `SFRB_A_TCTL: rd_cur = tctl_val;
      `SFRB_A_TIMER_MODE_CONTROL: rd_cur = timer_mode_control;
      `SFRB_A_T0L: rd_cur = timer_zero_low;
      `SFRB_A_T1L: rd_cur = timer_one_low;
      `SFRB_A_T0H: rd_cur = timer_zero_high;
      `SFRB_A_T1H: rd_cur = timer_one_high;
      default: rd_cur = `SFRB_RD_NONE;
    endcase
  end
  logic w_pal;
  logic w_pah;
  logic w_pbl;
  logic w_pbh;
  logic w_pwr;
  logic w_tctl;
  logic w_t0l;
  logic w_t0h;
  logic w_t1l;
  logic w_t1h;
  assign w_pal = we & (sfr_req.addr == `SFRB_A_PAL);
  assign w_pah = we & (sfr_req.addr == `SFRB_A_PAH);
  assign w_pbl = we & (sfr_req.addr == `SFRB_A_PBL);
  assign w_pbh = we & (sfr_req.addr == `SFRB_A_PBH);
  assign w_pwr = we & (sfr_req.addr == `SFRB_A_PWR);
  assign w_tctl = we & (sfr_req.addr == `SFRB_A_TCTL);
  assign w_t0l = we & (sfr_req.addr == `SFRB_A_T0L);
  assign w_t0h = we & (sfr_req.addr == `SFRB_A_T0H);
  assign w_t1l = we & (sfr_req.addr == `SFRB_A_T1L);
  assign w_t1h = we & (sfr_req.addr == `SFRB_A_T1H);

  // ****************************************
  // Data pointers
  // ****************************************
  logic [7:0] next_pal;
  logic [7:0] next_pah;
  logic [7:0] next_pbl;
  logic [7:0] next_pbh;
  logic next_psel;
  // A bus write to a byte outranks a pointer load in the same cycle
  assign next_pal = w_pal ? wv : (active_data_pointer_load & ~pointer_select) ? active_data_pointer_value[7:0] : pointer_a_low;
  assign next_pah = w_pah ? wv : (active_data_pointer_load & ~pointer_select) ? active_data_pointer_value[15:8] : pointer_a_high;
  assign next_pbl = w_pbl ? wv : (active_data_pointer_load & pointer_select) ? active_data_pointer_value[7:0] : pointer_b_low;
  assign next_pbh = w_pbh ? wv : (active_data_pointer_load & pointer_select) ? active_data_pointer_value[15:8] : pointer_b_high;
  assign next_psel = (we & (sfr_req.addr == `SFRB_A_PSEL)) ? wv[0] : pointer_select;

  // ****************************************
  // Power state
  // ****************************************
  sfrb_pkg::sfrb_pwr_t next_pwr;
  logic pd_set;
  logic idle_set;
  assign pd_set = w_pwr & wv[`SFRB_B_PDOWN];
  assign idle_set = w_pwr & wv[`SFRB_B_IDLE];
  always_comb
  begin
    case (pwr)
      sfrb_pkg::SFRB_RUN: next_pwr = pd_set ? sfrb_pkg::SFRB_PDOWN : idle_set ? sfrb_pkg::SFRB_IDLE : pwr;
      sfrb_pkg::SFRB_IDLE: next_pwr = wake ? sfrb_pkg::SFRB_RUN : pwr;
      sfrb_pkg::SFRB_PDOWN: next_pwr = wake ? sfrb_pkg::SFRB_RUN : pwr;
      default: next_pwr = sfrb_pkg::SFRB_RUN;
    endcase
  end

  // ****************************************
  // Tick dividers and pins
  // ****************************************
  logic tick12;
  logic tick4;
  logic tick0;
  logic tick1;
  // Dividers freeze in power-down, run on in idle
  assign tick12 = periph_clk_en & (div12 == 4'(`SFRB_DIV_SLOW - 1));
  assign tick4 = periph_clk_en & (div4 == 2'(`SFRB_DIV_FAST - 1));
  assign tick0 = timer_zero_div_select ? tick4 : tick12;
  assign tick1 = timer_one_div_select ? tick4 : tick12;
  logic c0_fall;
  logic c1_fall;
  logic x0_lvl;
  logic x1_lvl;
  logic x0_fall;
  logic x1_fall;
  sfrb_pin_sync u_c0 (.mclk(mclk), .srst(srst), .pin(t0_count_pin), .level(), .fall(c0_fall));
  sfrb_pin_sync u_c1 (.mclk(mclk), .srst(srst), .pin(t1_count_pin), .level(), .fall(c1_fall));
  sfrb_pin_sync u_x0 (.mclk(mclk), .srst(srst), .pin(ext_irq_pin_zero), .level(x0_lvl), .fall(x0_fall));
  sfrb_pin_sync u_x1 (.mclk(mclk), .srst(srst), .pin(ext_irq_pin_one), .level(x1_lvl), .fall(x1_fall));
  sfrb_ext_flag u_f0 (.mclk(mclk), .srst(srst), .level(x0_lvl), .fall(x0_fall), .edge_mode(ext_zero_trigger_type),
    .vec_ack(x0_vec), .sw_we(w_tctl), .sw_val(wv[`SFRB_B_X0F]), .flag(ext_zero_flag));
  sfrb_ext_flag u_f1 (.mclk(mclk), .srst(srst), .level(x1_lvl), .fall(x1_fall), .edge_mode(ext_one_trigger_type),
    .vec_ack(x1_vec), .sw_we(w_tctl), .sw_val(wv[`SFRB_B_X1F]), .flag(ext_one_flag));

  // ****************************************
  // Timers
  // ****************************************
  function automatic logic [16:0] sfrb_step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h0_0001;
    s8 = {1'b0, lo} + 9'h001;
    case (m)
      2'h0: sfrb_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      2'h1: sfrb_step = s16;
      2'h2: sfrb_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default: sfrb_step = {s8[8], hi, s8[7:0]};
    endcase
  endfunction
  sfrb_pkg::sfrb_tcfg_t cfg0;
  sfrb_pkg::sfrb_tcfg_t cfg1;
  logic split;
  logic en0;
  logic en0h;
  logic en1;
  logic [16:0] s0;
  logic [16:0] s1;
  logic [8:0] h0inc;
  logic ovf0;
  logic ovf1;
  assign cfg0 = timer_mode_control[3:0];
  assign cfg1 = timer_mode_control[7:4];
  assign split = cfg0.mode == sfrb_pkg::SFRB_MSPLIT;
  assign en0 = timer_zero_run & (~cfg0.gate | x0_lvl) & (cfg0.count_pin ? c0_fall : tick0);
  // Split high byte is a plain timer on the second timer's run bit
  assign en0h = split & timer_one_run & tick1;
  assign en1 = (cfg1.mode != sfrb_pkg::SFRB_MSPLIT) & timer_one_run & (~cfg1.gate | x1_lvl)
             & (cfg1.count_pin ? c1_fall : tick1);
  assign s0 = sfrb_step(cfg0.mode, timer_zero_low, timer_zero_high);
  assign s1 = sfrb_step(cfg1.mode, timer_one_low, timer_one_high);
  assign h0inc = {1'b0, timer_zero_high} + 9'h001;
  assign ovf0 = en0 & s0[16];
  assign ovf1 = split ? (en0h & h0inc[8]) : (en1 & s1[16]);
  logic [7:0] next_t0l;
  logic [7:0] next_t0h;
  logic [7:0] next_t1l;
  logic [7:0] next_t1h;
  logic next_t0f;
  logic next_t1f;
  assign next_t0l = w_t0l ? wv : en0 ? s0[7:0] : timer_zero_low;
  assign next_t0h = w_t0h ? wv : split ? (en0h ? h0inc[7:0] : timer_zero_high)
                  : en0 ? s0[15:8] : timer_zero_high;
  assign next_t1l = w_t1l ? wv : en1 ? s1[7:0] : timer_one_low;
  assign next_t1h = w_t1h ? wv : en1 ? s1[15:8] : timer_one_high;
  // Overflow beats a software or vector clear
  assign next_t0f = ovf0 | (w_tctl ? wv[`SFRB_B_T0F] : (~t0_vec & timer_zero_overflow));
  assign next_t1f = ovf1 | (w_tctl ? wv[`SFRB_B_T1F] : (~t1_vec & timer_one_overflow));

  // ****************************************
  // Flops
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      port_zero_latch <= `SFRB_RD_NONE;
      stack_top_pointer <= `SFRB_RST_STP;
      pointer_a_low <= `SFRB_RST_BYTE;
      pointer_a_high <= `SFRB_RST_BYTE;
      pointer_b_low <= `SFRB_RST_BYTE;
      pointer_b_high <= `SFRB_RST_BYTE;
      pointer_select <= 1'b0;
      active_data_pointer <= 16'h0000;
      {baud_doubler, framing_select, user_flag_one, user_flag_zero} <= 4'h0;
      {power_down_request, idle_request} <= 2'h0;
      pwr <= sfrb_pkg::SFRB_RUN;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      {timer_zero_run, timer_one_run, ext_zero_trigger_type, ext_one_trigger_type} <= 4'h0;
      {timer_zero_overflow, timer_one_overflow} <= 2'h0;
      timer_mode_control <= `SFRB_RST_BYTE;
      timer_zero_low <= `SFRB_RST_BYTE;
      timer_zero_high <= `SFRB_RST_BYTE;
      timer_one_low <= `SFRB_RST_BYTE;
      timer_one_high <= `SFRB_RST_BYTE;
      div12 <= 4'h0;
      div4 <= 2'h0;
      sfr_rdata <= `SFRB_RD_NONE;
      sfr_rbit <= 1'b1;
      sfr_rvalid <= 1'b0;
    end
    else
    begin
      if (we & (sfr_req.addr == `SFRB_A_PZL))
        port_zero_latch <= wv;
      if (we & (sfr_req.addr == `SFRB_A_STP))
        stack_top_pointer <= wv;
      if (we & (sfr_req.addr == `SFRB_A_TIMER_MODE_CONTROL))
        timer_mode_control <= wv;
      if (w_pwr)
      begin
        {baud_doubler, framing_select} <= wv[`SFRB_B_BAUD:`SFRB_B_FRAME];
        {user_flag_one, user_flag_zero} <= wv[`SFRB_B_UF1:`SFRB_B_UF0];
      end
      power_down_request <= (next_pwr == sfrb_pkg::SFRB_PDOWN);
      idle_request <= (next_pwr == sfrb_pkg::SFRB_IDLE);
      if (w_tctl)
      begin
        {timer_one_run, timer_zero_run} <= {wv[`SFRB_B_T1R], wv[`SFRB_B_T0R]};
        {ext_one_trigger_type, ext_zero_trigger_type} <= {wv[`SFRB_B_X1T], wv[`SFRB_B_X0T]};
      end
      pointer_a_low <= next_pal;
      pointer_a_high <= next_pah;
      pointer_b_low <= next_pbl;
      pointer_b_high <= next_pbh;
      pointer_select <= next_psel;
      active_data_pointer <= next_psel ? {next_pbh, next_pbl} : {next_pah, next_pal};
      pwr <= next_pwr;
      cpu_clk_en <= (next_pwr == sfrb_pkg::SFRB_RUN);
      periph_clk_en <= (next_pwr != sfrb_pkg::SFRB_PDOWN);
      timer_zero_low <= next_t0l;
      timer_zero_high <= next_t0h;
      timer_one_low <= next_t1l;
      timer_one_high <= next_t1h;
      timer_zero_overflow <= next_t0f;
      timer_one_overflow <= next_t1f;
      if (periph_clk_en)
      begin
        div12 <= tick12 ? 4'h0 : div12 + 4'h1;
        div4 <= div4 + 2'h1;
      end
      sfr_rvalid <= sfr_req.req & ~sfr_req.wr;
      if (sfr_req.req & ~sfr_req.wr)
      begin
        sfr_rdata <= hit ? rd_cur : `SFRB_RD_NONE;
        sfr_rbit <= hit ? rd_cur[sfr_req.bit_sel] : 1'b1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (srst);
  logic rd_any;
  assign rd_any = sfr_req.req & ~sfr_req.wr;
  a_hole_reads_high: assert property (rd_any && sfr_req.direct && sfr_req.addr == 8'h8f |=> sfr_rdata == 8'hff)
    else $error("unmapped location did not read ones");
  a_indirect_ignored: assert property (sfr_req.req && sfr_req.wr && !sfr_req.direct
    && sfr_req.addr == `SFRB_A_PZL |=> $stable(port_zero_latch))
    else $error("indirect write reached a register");
  a_bit_refused: assert property (sfr_req.req && sfr_req.wr && sfr_req.bit_op
    && sfr_req.addr == `SFRB_A_STP |=> $stable(stack_top_pointer))
    else $error("bit write on non bit-addressable register");
  a_sel_reserved: assert property (rd_any && sfr_req.direct && sfr_req.addr == `SFRB_A_PSEL
    |=> sfr_rdata[7:1] == 7'h00)
    else $error("pointer select reserved bits not zero");
  a_ptr_select: assert property (!$past(srst) |-> active_data_pointer ==
    (pointer_select ? {pointer_b_high, pointer_b_low} : {pointer_a_high, pointer_a_low}))
    else $error("active pointer mismatches select");
  a_ptr_load: assert property (active_data_pointer_load && !pointer_select && !(sfr_req.req && sfr_req.wr)
    |=> {pointer_a_high, pointer_a_low} == $past(active_data_pointer_value) && $stable({pointer_b_high, pointer_b_low}))
    else $error("pointer load hit the wrong pair");
  a_pd_stops: assert property (pwr == sfrb_pkg::SFRB_RUN && pd_set |=> !cpu_clk_en && !periph_clk_en
    && power_down_request)
    else $error("power down did not stop clocks");
  a_idle_keeps: assert property (pwr == sfrb_pkg::SFRB_RUN && idle_set && !pd_set
    |=> !cpu_clk_en && periph_clk_en)
    else $error("idle did not keep peripheral clock");
  a_ovf_sets: assert property (ovf0 |=> timer_zero_overflow)
    else $error("overflow flag not set");
  a_run_off: assert property (!timer_zero_run && !w_t0l |=> $stable(timer_zero_low))
    else $error("stopped timer moved");
  a_gate_low: assert property (cfg0.gate && !x0_lvl && !w_t0l |=> $stable(timer_zero_low))
    else $error("gated timer counted with pin low");
  a_reload: assert property (en0 && cfg0.mode == sfrb_pkg::SFRB_M8R && timer_zero_low == 8'hff && !w_t0l
    |=> timer_zero_low == $past(timer_zero_high))
    else $error("mode 2 reload failed");
  a_slow_tick: assert property (tick12 |=> !tick12 [*8])
    else $error("slow tick too frequent");
  c_t0_ovf: cover property (ovf0 && cfg0.mode == sfrb_pkg::SFRB_M16);
  c_split_ovf: cover property (ovf1 && split);
  c_idle_wake: cover property (pwr == sfrb_pkg::SFRB_IDLE && wake);
  c_bit_write: cover property (we && sfr_req.bit_op && sfr_req.addr == `SFRB_A_TCTL);
endmodule

//--- rtl/sfrb_cfg.svh
// Register addresses, bit positions, reset values and divider counts
`ifndef SFRB_CFG_SVH
`define SFRB_CFG_SVH
`define SFRB_A_PZL 8'h80
`define SFRB_A_STP 8'h81
`define SFRB_A_PAL 8'h82
`define SFRB_A_PAH 8'h83
`define SFRB_A_PBL 8'h84
`define SFRB_A_PBH 8'h85
`define SFRB_A_PSEL 8'h86
`define SFRB_A_PWR 8'h87
`define SFRB_A_TCTL 8'h88
`define SFRB_A_TIMER_MODE_CONTROL 8'h89
`define SFRB_A_T0L 8'h8a
`define SFRB_A_T1L 8'h8b
`define SFRB_A_T0H 8'h8c
`define SFRB_A_T1H 8'h8d
`define SFRB_B_IDLE 0
`define SFRB_B_PDOWN 1
`define SFRB_B_UF0 2
`define SFRB_B_UF1 3
`define SFRB_B_FRAME 6
`define SFRB_B_BAUD 7
`define SFRB_B_X0T 0
`define SFRB_B_X0F 1
`define SFRB_B_X1T 2
`define SFRB_B_X1F 3
`define SFRB_B_T0R 4
`define SFRB_B_T0F 5
`define SFRB_B_T1R 6
`define SFRB_B_T1F 7
`define SFRB_RST_BYTE 8'h00
`define SFRB_RST_STP 8'h07
`define SFRB_RD_NONE 8'hff
`define SFRB_DIV_FAST 4
`define SFRB_DIV_SLOW 12
`endif

//--- rtl/sfrb_pkg.sv
// Types shared by the register bank files
package sfrb_pkg;
  typedef enum logic [1:0] {
    SFRB_M13 = 2'h0,
    SFRB_M16 = 2'h1,
    SFRB_M8R = 2'h2,
    SFRB_MSPLIT = 2'h3
  } sfrb_tmode_t;
  typedef struct packed {
    logic gate;
    logic count_pin;
    sfrb_tmode_t mode;
  } sfrb_tcfg_t;
  typedef enum logic [1:0] {
    SFRB_RUN = 2'h0,
    SFRB_IDLE = 2'h1,
    SFRB_PDOWN = 2'h3
  } sfrb_pwr_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic direct;
    logic bit_op;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrb_req_t;
endpackage

//--- rtl/sfrb_pin_sync.sv
// Pin synchroniser with falling edge detect
`timescale 1ns/100ps
module sfrb_pin_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta;
  logic prev;
  // First stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta <= 1'b1;
      level <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end
  assign fall = prev & ~level;
endmodule

//--- rtl/sfrb_ext_flag.sv
// External interrupt flag, edge or level triggered
`timescale 1ns/100ps
module sfrb_ext_flag (
  input wire logic mclk,
  input wire logic srst,
  input wire logic level,
  input wire logic fall,
  input wire logic edge_mode,
  input wire logic vec_ack,
  input wire logic sw_we,
  input wire logic sw_val,
  output logic flag
);
  logic next_flag;
  // Edge set beats any clear in the same cycle
  assign next_flag = ~edge_mode ? ~level : fall ? 1'b1 : sw_we ? sw_val : vec_ack ? 1'b0 : flag;
  always_ff @(posedge mclk)
  begin
    if (srst)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (srst);
  a_level_tracks: assert property (!edge_mode && !$past(srst) |=> flag == !$past(level))
    else $error("level flag does not follow pin");
  a_edge_sets: assert property (edge_mode && fall |=> flag)
    else $error("falling edge did not set flag");
  a_edge_vec: assert property (edge_mode && flag && vec_ack && !fall && !sw_we |=> !flag)
    else $error("vector did not clear edge flag");
endmodule

//--- dv/sfrb_cpu_model.sv
// CPU core model issuing direct and indirect register accesses
`timescale 1ns/100ps
module sfrb_cpu_model (
  input wire logic mclk,
  output sfrb_pkg::sfrb_req_t sfr_req
);
  initial sfr_req = '0;
  // One access, launched at a falling edge and held across the taking edge
  task automatic acc(input logic w, input logic dir, input logic bop, input logic [2:0] bs, input logic bv,
      input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_req <= '{req: 1'b1, wr: w, direct: dir, bit_op: bop, bit_sel: bs, bit_val: bv, addr: a, wdata: d};
    @(negedge mclk);
    // Released fields show inverted junk, never the old value
    sfr_req <= '{req: 1'b0, wr: ~w, direct: ~dir, bit_op: ~bop, bit_sel: ~bs, bit_val: ~bv, addr: ~a, wdata: ~d};
  endtask
endmodule

//--- dv/test_sfr_bank_timers_active_data_pointer_power.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module test_sfr_bank_timers_active_data_pointer_power;
  logic mclk = 1'b0, srst = 1'b1, active_data_pointer_load = 1'b0, wake = 1'b0, d0 = 1'b0, d1 = 1'b0;
  logic c0 = 1'b1, c1 = 1'b1, x0 = 1'b1, x1 = 1'b1, t0v = 1'b0, t1v = 1'b0, x0v = 1'b0, x1v = 1'b0;
  logic [15:0] dval = 16'h0000, adp;
  logic [7:0] rdata, pal, pbl, pbh, p0, pz;
  logic rbit, rvalid, cpu_en, per_en, baud, frame, tf0, tf1, xf0, xf1;
  sfrb_pkg::sfrb_req_t req;
  int miscompares = 0, check_count = 0;
  logic [8:0] exp_q[$];
  always #4 mclk = ~mclk;
  sfrb_cpu_model cpu (.mclk(mclk), .sfr_req(req));
  sfrb_bank dut (.mclk(mclk), .srst(srst), .sfr_req(req), .sfr_rdata(rdata), .sfr_rbit(rbit),
    .sfr_rvalid(rvalid), .active_data_pointer_load(active_data_pointer_load), .active_data_pointer_value(dval), .active_data_pointer(adp), .wake(wake),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .baud_doubler(baud), .framing_select(frame),
    .port_zero_latch(p0), .timer_zero_div_select(d0), .timer_one_div_select(d1), .t0_count_pin(c0),
    .t1_count_pin(c1), .ext_irq_pin_zero(x0), .ext_irq_pin_one(x1), .t0_vec(t0v), .t1_vec(t1v),
    .x0_vec(x0v), .x1_vec(x1v), .timer_zero_overflow(tf0), .timer_one_overflow(tf1),
    .ext_zero_flag(xf0), .ext_one_flag(xf1));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Read results are matched in order, sampled mid-cycle where they are settled
  always @(negedge mclk)
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(16'hdead, 16'h0000);
      else
        chk({7'h00, rbit, rdata}, {7'h00, exp_q.pop_front()});
    end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.acc(1'b1, 1'b1, 1'b0, 3'h0, 1'b0, a, d);
  endtask
  // A plain read shows bit zero on the bit output
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({e[0], e});
    cpu.acc(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, a, 8'h00);
  endtask
  task automatic tb(input logic [7:0] a, input logic [2:0] bs, input logic [7:0] e);
    exp_q.push_back({e[bs], e});
    cpu.acc(1'b0, 1'b1, 1'b1, bs, 1'b0, a, 8'h00);
  endtask
  // Pulses long enough to pass the pin synchroniser
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk) c0 = 1'b0;
      repeat (4) @(negedge mclk);
      c0 = 1'b1;
      repeat (4) @(negedge mclk);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return tf0;
      1: return xf0;
      3: return tf1;
      default: return cpu_en;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic await(input int k, input logic v);
    for (int i = 0; i < 64 && sig(k) !== v; i++)
      @(negedge mclk);
    chk({15'h0000, sig(k)}, {15'h0000, v});
    if (sig(k) !== v)
      conclude();
  endtask
  initial
  begin
    void'($urandom(76));
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    cpu.acc(1'b1, 1'b1, 1'b1, 3'h0, 1'b0, 8'h81, 8'h00);
    rd(8'h81, 8'h07);
    rd(8'h80, 8'hff);
    rd(8'h8e, 8'hff);
    rd(8'h8f, 8'hff);
    rd(8'h87, 8'h30);
    $display("reset values done");
    pal = 8'($urandom());
    pbl = 8'($urandom());
    pbh = 8'($urandom());
    wr(8'h82, pal);
    wr(8'h84, pbl);
    wr(8'h85, pbh);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'h01);
    chk(adp, {pbh, pbl});
    dval = 16'($urandom());
    @(negedge mclk) active_data_pointer_load = 1'b1;
    @(negedge mclk) active_data_pointer_load = 1'b0;
    chk(adp, dval);
    rd(8'h84, dval[7:0]);
    rd(8'h82, pal);
    dval = ~dval;
    wr(8'h86, 8'h00);
    @(negedge mclk) active_data_pointer_load = 1'b1;
    @(negedge mclk) active_data_pointer_load = 1'b0;
    chk(adp, dval);
    rd(8'h83, dval[15:8]);
    rd(8'h84, ~dval[7:0]);
    $display("pointers done");
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hfe);
    wr(8'h8a, 8'hfe);
    cpu.acc(1'b1, 1'b1, 1'b1, 3'h4, 1'b1, 8'h88, 8'h00);
    await(0, 1'b1);
    wr(8'h88, 8'h20);
    rd(8'h8a, 8'hfe);
    rd(8'h88, 8'h20);
    @(negedge mclk) t0v = 1'b1;
    @(negedge mclk) t0v = 1'b0;
    chk({15'h0000, tf0}, 16'h0000);
    cpu.acc(1'b1, 1'b1, 1'b1, 3'h0, 1'b1, 8'h89, 8'h00);
    rd(8'h89, 8'h02);
    cpu.acc(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 8'h8c, 8'h55);
    rd(8'h8c, 8'hfe);
    $display("timer done");
    wr(8'h88, 8'h01);
    @(negedge mclk) x0 = 1'b0;
    await(1, 1'b1);
    @(negedge mclk) x0v = 1'b1;
    @(negedge mclk) x0v = 1'b0;
    chk({15'h0000, xf0}, 16'h0000);
    x0 = 1'b1;
    $display("external flag done");
    wr(8'h87, 8'hcc);
    rd(8'h87, 8'hfc);
    chk({14'h0000, baud, frame}, 16'h0003);
    wr(8'h87, 8'h01);
    await(2, 1'b0);
    chk({15'h0000, per_en}, 16'h0001);
    @(negedge mclk) wake = 1'b1;
    @(negedge mclk) wake = 1'b0;
    await(2, 1'b1);
    wr(8'h87, 8'h02);
    await(2, 1'b0);
    chk({15'h0000, per_en}, 16'h0000);
    @(negedge mclk) wake = 1'b1;
    @(negedge mclk) wake = 1'b0;
    await(2, 1'b1);
    $display("power done");
    d0 = 1'b1;
    d1 = 1'b1;
    wr(8'h89, 8'h00);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    await(0, 1'b1);
    wr(8'h88, 8'h00);
    rd(8'h8a, 8'he0);
    rd(8'h8c, 8'h00);
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hfd);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    // Three fast ticks fit in 13 cycles; the slow tick would need 25
    repeat (13) @(negedge mclk);
    chk({15'h0000, tf0}, 16'h0001);
    wr(8'h88, 8'h00);
    rd(8'h8c, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h40);
    await(3, 1'b1);
    wr(8'h88, 8'h00);
    rd(8'h8c, 8'h00);
    chk({15'h0000, tf1}, 16'h0000);
    wr(8'h89, 8'h0d);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    x0 = 1'b0;
    pulses(3);
    rd(8'h8a, 8'h00);
    x0 = 1'b1;
    repeat (4) @(negedge mclk);
    pulses(3);
    wr(8'h88, 8'h00);
    rd(8'h8a, 8'h03);
    x1 = 1'b0;
    repeat (4) @(negedge mclk);
    chk({15'h0000, xf1}, 16'h0001);
    tb(8'h88, 3'h3, 8'h08);
    tb(8'h89, 3'h0, 8'hff);
    x1 = 1'b1;
    pz = 8'($urandom());
    wr(8'h80, pz);
    cpu.acc(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 8'h80, ~pz);
    chk({8'h00, p0}, {8'h00, pz});
    $display("modes done");
    repeat (4) @(negedge mclk);
    chk(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
